// ---- tape_chk_device.sv ----
`include "tape_chk_consts.svh"
module tape_chk_device #(
    parameter int TEST_SHORT_CYC = `TEST_SHORT_CYC,
    parameter int BLOCK_GAP_CYC  = `BLOCK_GAP_CYC
) (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    // host side
    tape_chk_if.device              bus,
    // tape side events
    input  wire logic               i_read_bit_seen,
    input  wire logic               i_skew_gate,
    input  wire logic               i_write_underrun,
    input  wire logic               i_char_complete_clock,
    input  wire logic               i_first_bit_clock,
    input  wire tape_chk_pkg::chan_t i_read_char,
    input  wire logic               i_buffer_first_flag,
    input  wire logic               i_forward_request,
    input  wire logic               i_reverse_request,
    input  wire logic               i_unit_addressed_ff,
    input  wire logic               i_gap,
    input  wire logic               i_gap_check_timer,
    input  wire logic               i_block_end,
    // deskew sources
    input  wire tape_chk_pkg::chan_t i_fwd_deskew,
    input  wire tape_chk_pkg::chan_t i_rev_deskew,
    input  wire tape_chk_pkg::chan_t i_write_deskew,
    // outputs
    output tape_chk_pkg::chan_t     o_read_bus,
    output logic                    o_buffer_clock,
    output logic                    o_char_parity_en,
    output logic                    o_forward_activate,
    output logic                    o_write_activate,
    output logic                    o_toggle_enable,
    output logic                    o_block_timer_done,
    output logic                    o_read_timing_error
);
    import tape_chk_pkg::*;
    logic skew_ff, full_det_ff, clk_det_ff, tape_mark, read_inhibit;
    logic gap_irq_en, write_error, skew_fall, full_fall, test_active;
    logic [1:0] chars_read;
    logic [31:0] block_cnt;
    logic is_write, is_read;
    assign is_write = (bus.op_kind == OP_WRITE);
    assign is_read  = (bus.op_kind == OP_READ);
    assign test_active = bus.test_mode & i_unit_addressed_ff;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || !i_skew_gate) begin
            skew_ff <= 1'b0;
        end else if (is_write && i_read_bit_seen) begin
            skew_ff <= 1'b1;
        end
    end
    tape_fall_det u_skew_fall (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_level (skew_ff),
        .o_fall  (skew_fall)
    );
    tape_fall_det u_full_fall (
        .i_clk   (i_clk),
        .i_rst_b (i_rst_b),
        .i_level (full_det_ff),
        .o_fall  (full_fall)
    );

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.op_start) begin
            clk_det_ff  <= 1'b0;
            full_det_ff <= 1'b0;
        end else if (read_inhibit) begin
            clk_det_ff  <= 1'b0;
            full_det_ff <= 1'b0;
        end else if (is_write) begin
            full_det_ff <= i_write_underrun & ~full_det_ff;
        end else if (is_read && i_char_complete_clock) begin
            if (!clk_det_ff) begin
                clk_det_ff <= 1'b1;
            end else begin
                full_det_ff <= 1'b1;
            end
        end
    end
    assign o_read_timing_error = is_read & clk_det_ff & full_det_ff
                               & i_first_bit_clock;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.op_start) begin
            write_error <= 1'b0;
        end else if (skew_fall || (is_write && full_fall)) begin
            write_error <= 1'b1;
        end
    end
    assign bus.write_error = write_error;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            tape_mark <= 1'b0;
        end else if (bus.op_start) begin
            tape_mark <= 1'b1;
        end else if (is_read && i_char_complete_clock
                     && i_read_char != `TM_PATTERN) begin
            tape_mark <= 1'b0;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.op_start) begin
            read_inhibit <= 1'b0;
        end else if (bus.output_command_instr && bus.read_inhibit_cmd) begin
            read_inhibit <= 1'b1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.op_start) begin
            chars_read <= 2'h0;
        end else if (i_char_complete_clock
                     && chars_read != `CHARS_BEFORE_INHIBIT) begin
            chars_read <= chars_read + 2'h1;
        end
    end
    logic suppress;
    assign suppress = read_inhibit && chars_read == `CHARS_BEFORE_INHIBIT
                    && i_buffer_first_flag
                    && (i_forward_request || i_reverse_request);
    assign o_buffer_clock = i_char_complete_clock & ~suppress;
    assign o_char_parity_en = ~suppress;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            gap_irq_en <= 1'b0;
        // set wins over a start in the same cycle
        end else if (bus.output_command_instr
                     && bus.cmd_bits == `CMD_GAP_ENABLE) begin
            gap_irq_en <= 1'b1;
        end else if (bus.op_start) begin
            gap_irq_en <= 1'b0;
        end
    end
    assign bus.gap_irq = gap_irq_en & i_gap & i_gap_check_timer;
    assign bus.skip_result = bus.skip_on_signal_instr
                           & (bus.skip_sel_gap ? i_gap : tape_mark);

    assign o_forward_activate = i_unit_addressed_ff & i_forward_request
                              & ~bus.test_mode;
    assign o_write_activate = i_unit_addressed_ff & is_write
                            & ~bus.test_mode;
    assign o_toggle_enable = is_write;

    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_read_bus <= 7'h00;
        end else begin
            o_read_bus <= ((i_fwd_deskew | i_rev_deskew) & {7{~test_active}})
                        | (i_write_deskew & {7{test_active}});
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_b || bus.op_start) begin
            block_cnt <= 32'h0;
        end else if (i_block_end && !o_block_timer_done) begin
            block_cnt <= block_cnt + 32'h1;
        end
    end
    assign o_block_timer_done = block_cnt >= (test_active
        ? 32'(BLOCK_GAP_CYC - TEST_SHORT_CYC) : 32'(BLOCK_GAP_CYC));
endmodule

// ---- tape_chk_consts.svh ----
// What this block does
// - skew flop set by read bit in gate
// - skew flop falling edge sets write error
// - pulse full-detect when write data missing
// - full-detect falling edge sets write error
// - two read clocks then first-bit clock errors
// - operation start presets tape-mark flop
// - non tape-mark character clears tape-mark flop
// - tape-mark state presented to skip test
// - host output command sets read inhibit
// - suppress buffer clocks after two chars, flag
// - read inhibit holds detect flops cleared
// - skipped chars skip character parity check
// - gap condition presented to skip test
// - gap-enable command sets gap interrupt enable
// - operation start clears gap interrupt enable
// - gap interrupt after check timer in gap
// - test mode inhibits motion and write drive
// - test mode loops write deskew to read
// - read bus ORs forward, reverse; test mode selects write deskew alone
// - test mode shortens block timing 4 ms
// - test mode keeps write toggles enabled
`ifndef TAPE_CHK_CONSTS_SVH
`define TAPE_CHK_CONSTS_SVH
`define CHANNELS        7
`define CMD_BITS        5
`define CMD_GAP_ENABLE  5'h1F
`define TM_PATTERN      7'h78
`define CLK_MHZ         50
`define TEST_SHORT_MS   4
`define TEST_SHORT_CYC  (`TEST_SHORT_MS * 1000 * `CLK_MHZ)
`define BLOCK_GAP_CYC   (12 * 1000 * `CLK_MHZ)
`define CHARS_BEFORE_INHIBIT 2'h2
`endif

// ---- tape_chk_pkg.sv ----
package tape_chk_pkg;
    typedef logic [6:0] chan_t;
    typedef logic [4:0] cmd_t;
    typedef enum logic [1:0] {OP_IDLE, OP_READ, OP_WRITE} op_t;
endpackage

// ---- tape_chk_if.sv ----
interface tape_chk_if;
    import tape_chk_pkg::*;
    logic  op_start;
    op_t   op_kind;
    logic  test_mode;
    logic  output_command_instr;
    cmd_t  cmd_bits;
    logic  read_inhibit_cmd;
    logic  skip_on_signal_instr;
    logic  skip_sel_gap;
    logic  skip_result;
    logic  gap_irq;
    logic  write_error;
    modport device (
        input  op_start, op_kind, test_mode, output_command_instr,
        input  cmd_bits, read_inhibit_cmd, skip_on_signal_instr,
        input  skip_sel_gap,
        output skip_result, gap_irq, write_error
    );
    modport host (
        output op_start, op_kind, test_mode, output_command_instr,
        output cmd_bits, read_inhibit_cmd, skip_on_signal_instr,
        output skip_sel_gap,
        input  skip_result, gap_irq, write_error
    );
endinterface

// ---- tape_fall_det.sv ----
module tape_fall_det (
    // clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst_b,
    // level in, pulse out
    input  wire logic i_level,
    output logic      o_fall
);
    logic prev;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            prev <= 1'b0;
        end else begin
            prev <= i_level;
        end
    end
    assign o_fall = prev & ~i_level;
endmodule

// ---- tape_chk_host.sv ----
module tape_chk_host (
    // clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst_b,
    // user requests
    input  wire logic                i_start,
    input  wire tape_chk_pkg::op_t   i_op_kind,
    input  wire logic                i_test_mode,
    input  wire logic                i_cmd_valid,
    input  wire tape_chk_pkg::cmd_t  i_cmd_bits,
    input  wire logic                i_cmd_inhibit,
    input  wire logic                i_skip_valid,
    input  wire logic                i_skip_gap,
    // results
    output logic                     o_skip_taken,
    output logic                     o_gap_irq,
    output logic                     o_write_error,
    // device side
    tape_chk_if.host                 bus
);
    import tape_chk_pkg::*;
    op_t op_kind;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            op_kind <= OP_IDLE;
        end else if (i_start) begin
            op_kind <= i_op_kind;
        end
    end
    assign bus.op_start  = i_start;
    assign bus.op_kind   = op_kind;
    assign bus.test_mode = i_test_mode;
    // inhibit via output command; gap enable
    assign bus.output_command_instr = i_cmd_valid;
    assign bus.cmd_bits             = i_cmd_bits;
    assign bus.read_inhibit_cmd     = i_cmd_inhibit;
    assign bus.skip_on_signal_instr = i_skip_valid;
    assign bus.skip_sel_gap         = i_skip_gap;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_skip_taken  <= 1'b0;
            o_gap_irq     <= 1'b0;
            o_write_error <= 1'b0;
        end else begin
            o_skip_taken  <= bus.skip_result;
            o_gap_irq     <= bus.gap_irq;
            o_write_error <= bus.write_error;
        end
    end
endmodule

// ---- tape_chk_chk.sv ----
`include "tape_chk_consts.svh"
module tape_chk_chk (
    // clock and reset
    input  wire logic               i_clk,
    input  wire logic               i_rst_b,
    // interface signals
    input  wire logic               op_start,
    input  wire tape_chk_pkg::op_t  op_kind,
    input  wire logic               output_command_instr,
    input  wire tape_chk_pkg::cmd_t cmd_bits,
    input  wire logic               skip_on_signal_instr,
    input  wire logic               skip_sel_gap,
    input  wire logic               skip_result,
    input  wire logic               gap_irq,
    input  wire logic               write_error
);
    timeunit 1ns;
    timeprecision 1ns;
    import tape_chk_pkg::*;
    logic en_seen;
    logic tm_low;
    logic tm_ask;
    assign tm_ask = skip_on_signal_instr && !skip_sel_gap;
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // permissive: the gap-enable code 5'h1F seen since start allows the interrupt
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            en_seen <= 1'b0;
        end else if (output_command_instr && cmd_bits == `CMD_GAP_ENABLE) begin
            en_seen <= 1'b1;
        end else if (op_start) begin
            en_seen <= 1'b0;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b || op_start) begin
            tm_low <= 1'b0;
        end else if (tm_ask && !skip_result) begin
            tm_low <= 1'b1;
        end
    end
    a_werr_holds: assert property (
        write_error && !op_start |=> write_error)
        else $error("write error dropped");
    a_werr_start_clears: assert property (
        op_start |=> !write_error [*2])
        else $error("write error not cleared by start");
    a_werr_in_write: assert property (
        $rose(write_error) |-> op_kind == OP_WRITE)
        else $error("write error outside write");
    a_gap_start_clears: assert property (
        op_start && !output_command_instr |=> !gap_irq)
        else $error("gap interrupt after start");
    a_gap_needs_enable: assert property (
        gap_irq |-> en_seen)
        else $error("gap interrupt without enable");
    a_gap_in_op: assert property (
        gap_irq |-> op_kind != OP_IDLE)
        else $error("gap interrupt while idle");
    a_tmark_preset: assert property (
        op_start ##1 tm_ask |-> skip_result)
        else $error("tape mark not preset");
    a_tmark_sticky: assert property (
        tm_ask && tm_low |-> !skip_result)
        else $error("tape mark set again");
endmodule

// ---- testbench.sv ----
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import tape_chk_pkg::*;
    logic  i_clk, i_rst_b, st, ck_v, ck_inh, sk_v, sk_gap, tmode;
    op_t   kind;
    cmd_t  ck_bits;
    logic  rbs, sg, wu, cc, fb, bff, fr, rr, ua, gp, gct, be;
    chan_t rc, fd, rd, wd, rbus;
    logic  bclk, cpe, fact, wact, tog, btd, rte, skt, werr, gi;
    int    mismatches, samples_checked, cyc;
    tape_chk_if tif ();
    // short counts keep the run brief: normal 12, test 8
    tape_chk_device #(.TEST_SHORT_CYC(4), .BLOCK_GAP_CYC(12))
    tape_chk_device_inst (.i_clk, .i_rst_b, .bus(tif),
        .i_read_bit_seen(rbs), .i_skew_gate(sg), .i_write_underrun(wu),
        .i_char_complete_clock(cc), .i_first_bit_clock(fb),
        .i_read_char(rc), .i_buffer_first_flag(bff),
        .i_forward_request(fr), .i_reverse_request(rr),
        .i_unit_addressed_ff(ua), .i_gap(gp), .i_gap_check_timer(gct),
        .i_block_end(be), .i_fwd_deskew(fd), .i_rev_deskew(rd),
        .i_write_deskew(wd), .o_read_bus(rbus), .o_buffer_clock(bclk),
        .o_char_parity_en(cpe), .o_forward_activate(fact),
        .o_write_activate(wact), .o_toggle_enable(tog),
        .o_block_timer_done(btd), .o_read_timing_error(rte));
    tape_chk_host tape_chk_host_inst (.i_clk, .i_rst_b, .i_start(st),
        .i_op_kind(kind), .i_test_mode(tmode), .i_cmd_valid(ck_v),
        .i_cmd_bits(ck_bits), .i_cmd_inhibit(ck_inh),
        .i_skip_valid(sk_v), .i_skip_gap(sk_gap), .o_skip_taken(skt),
        .o_gap_irq(gi), .o_write_error(werr), .bus(tif));
    tape_chk_chk tape_chk_chk_inst (.i_clk, .i_rst_b,
        .op_start(tif.op_start), .op_kind(tif.op_kind),
        .output_command_instr(tif.output_command_instr),
        .cmd_bits(tif.cmd_bits),
        .skip_on_signal_instr(tif.skip_on_signal_instr),
        .skip_sel_gap(tif.skip_sel_gap), .skip_result(tif.skip_result),
        .gap_irq(tif.gap_irq), .write_error(tif.write_error));
    task nx(int n = 1);
        repeat (n) @(posedge i_clk);
    endtask
    task chk1(logic g, logic e, string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task chk7(chan_t g, chan_t e, string m);
        samples_checked++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, m);
        end
    endtask
    task start(op_t k);
        nx;
        st <= 1;
        kind <= k;
        nx;
        st <= 0;
    endtask
    task cc2;
        cc <= 1;
        nx;
        cc <= 0;
        nx;
    endtask
    task cmd(logic inh, cmd_t b);
        ck_v <= 1;
        ck_inh <= inh;
        ck_bits <= b;
        nx;
        ck_v <= 0;
        ck_inh <= 0;
    endtask
    task close_out;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task s_skew;
        start(OP_WRITE);
        sg <= 1;
        rbs <= 1;
        nx;
        sg <= 0;
        rbs <= 0;
        nx;
        #1 chk1(tif.write_error, 0, "early write error");
        nx;
        #1 chk1(tif.write_error, 1, "no skew error");
        nx(6);
        #1 chk1(werr, 1, "write error lost");
    endtask
    task s_under;
        start(OP_WRITE);
        wu <= 1;
        #1 chk1(tif.write_error, 0, "error kept past start");
        nx;
        wu <= 0;
        nx(4);
        #1 chk1(tif.write_error, 1, "no underrun error");
    endtask
    task s_rtime;
        start(OP_READ);
        cc2;
        cc2;
        fb <= 1;
        #1 chk1(rte, 1, "no read timing error");
        start(OP_READ);
        fb <= 0;
        cmd(1, 5'h00);
        cc2;
        cc2;
        fb <= 1;
        #1 chk1(rte, 0, "timing error under inhibit");
        nx;
        fb <= 0;
    endtask
    // reverse motion here; no case checks suppression under forward motion
    task s_inhibit;
        start(OP_READ);
        rr <= 1;
        bff <= 1;
        cc <= 1;
        #1 chk1(bclk, 1, "first char not clocked");
        chk1(cpe, 1, "parity check off");
        nx;
        cc <= 0;
        nx;
        cc2;
        cmd(1, 5'h00);
        cc <= 1;
        #1 chk1(bclk, 0, "clock not suppressed");
        chk1(cpe, 0, "skipped char parity checked");
        nx;
        {cc, rr, bff} <= '0;
    endtask
    task s_tmark;
        start(OP_READ);
        sk_v <= 1;
        rc <= 7'h78;
        cc <= 1;
        #1 chk1(tif.skip_result, 1, "tape mark not preset");
        nx;
        cc <= 0;
        #1 chk1(skt, 1, "host skip copy");
        chk1(tif.skip_result, 1, "mark char cleared flag");
        nx;
        rc <= 7'h79;
        cc2;
        #1 chk1(tif.skip_result, 0, "non mark char kept flag");
        nx(2);
        sk_v <= 0;
    endtask
    task s_gap;
        start(OP_READ);
        {gp, sk_v, sk_gap} <= '1;
        #1 chk1(tif.skip_result, 1, "gap not seen");
        nx;
        gp <= 0;
        #1 chk1(tif.skip_result, 0, "gap stuck");
        nx;
        {sk_v, sk_gap} <= '0;
        // gap held so only the enable gates the interrupt
        {gp, gct} <= '1;
        cmd(0, 5'h1E);
        #1 chk1(tif.gap_irq, 0, "wrong code enabled");
        cmd(0, 5'h1F);
        #1 chk1(tif.gap_irq, 1, "no gap interrupt");
        nx;
        gct <= 0;
        #1 chk1(tif.gap_irq, 0, "interrupt before timer");
        chk1(gi, 1, "host gap copy missing");
        nx;
        gct <= 1;
        start(OP_READ);
        #1 chk1(tif.gap_irq, 0, "enable kept past start");
        {gp, gct} <= '0;
    endtask
    task s_test;
        {ua, tmode, fr} <= '1;
        {wd, fd, rd} <= {7'h55, 7'h2A, 7'h01};
        start(OP_WRITE);
        be <= 1;
        #1 chk1(fact, 0, "motion in test");
        chk1(wact, 0, "write drive in test");
        chk1(tog, 1, "toggles stopped");
        nx;
        #1 chk7(rbus, 7'h55, "no loop back");
        nx(3);
        #1 chk1(btd, 0, "block timer early");
        nx(5);
        #1 chk1(btd, 1, "test timing not short");
        {be, tmode} <= '0;
        start(OP_WRITE);
        be <= 1;
        #1 chk1(fact, 1, "no forward drive");
        chk1(wact, 1, "no write drive");
        nx;
        #1 chk7(rbus, 7'h2B, "read bus not or");
        nx(9);
        #1 chk1(btd, 0, "normal timer early");
        nx(6);
        #1 chk1(btd, 1, "normal timer late");
        be <= 0;
    endtask
    initial begin
        i_clk = 0;
        forever #10 i_clk = ~i_clk;
    end
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            close_out;
        end
    end
    initial begin
        {i_rst_b, st, ck_v, ck_inh, sk_v, sk_gap, tmode, ck_bits} = '0;
        {rbs, sg, wu, cc, fb, bff, fr, rr, ua, gp, gct, be} = '0;
        {rc, fd, rd, wd} = '0;
        kind = OP_IDLE;
        {mismatches, samples_checked, cyc} = '0;
        nx(4);
        i_rst_b <= 1;
        s_skew;
        s_under;
        s_rtime;
        s_inhibit;
        s_tmark;
        s_gap;
        s_test;
        nx;
        close_out;
    end
endmodule
